// ==== hw/usb_function_power_endpoint_ctrl.v ====
/*
  usb function controller power, reset-source, indirect access and
  endpoint 1-3 in control. assumes link events arrive as levels from
  the transceiver side (synchronised here) and firmware on the sfr port.
*/
// Summary of operation
// - usb selected as source: bus reset while enabled raises system reset
// - usb selected as source: vbus matching chosen polarity raises system reset
// - select bit reads one after usb reset; reset pin never driven
// - suspend ends on resume, bus reset, or any device or controller reset
// - bus resume exits suspend; resume interrupt only when enabled
// - resume bit drives remote wakeup; software clears it 10-15 ms later
// - iso update: newly loaded iso in packets held until next start-of-frame
// - iso update: in token before start-of-frame answered with zero-length packet
// - disabled after power-on; enabled only when software clears inhibit bit
// - inhibit returns to one only on power-on or written soft reset
// - index register maps one endpoint's control registers at a time
// - split bit set: endpoint runs in and out pipes together
// - split clear: endpoint runs one direction chosen by direction select
// - iso bit picks isochronous mode, else bulk/interrupt handled alike
// - in interrupt on sent packet, flush of non-empty fifo, or hardware stall
// - packet-ready set: next in token sends data, clears bit, raises interrupt
`timescale 1ns/1ps
`include "usb_power_ep_map.vh"
module usb_function_power_endpoint_ctrl (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire [7:0] sfr_addr_in,
  input  wire [7:0] sfr_wdata_in,
  input  wire       sfr_wr_in,
  input  wire       sfr_rd_in,
  output wire       sfr_ready_out,
  output reg  [7:0] sfr_rdata_out,
  input  wire       resume_irq_enable_in,
  input  wire       vbus_in,
  input  wire       bus_reset_in,
  input  wire       bus_resume_in,
  input  wire       bus_suspend_in,
  input  wire       sof_in,
  input  wire       in_token_in,
  input  wire [1:0] in_token_ep_in,
  input  wire       tx_ready_in,
  output wire       tx_valid_out,
  output wire [7:0] tx_data_out,
  output wire       tx_last_out,
  output reg        tx_zero_len_out,
  output reg        tx_stall_out,
  output reg        tx_nak_out,
  output reg        system_reset_out,
  output wire       remote_wakeup_out,
  output wire       osc_suspend_out,
  output wire       function_enabled_out,
  output wire [3:1] ep_in_pipe_en_out,
  output wire [3:1] ep_out_pipe_en_out,
  output wire       irq_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam [7:0] POWER_RST = `POWER_RESET;

  // power-on domain registers
  reg  [7:0] indirect_address_port;
  reg  [7:0] indirect_data_port;
  reg        usb_reset_source_select;
  reg        vbus_polarity_select;
  reg        soft_rst;
  reg  [4:0] sysrst_cnt;
  // controller domain registers; sync_a to tok_ep_b reset on power-on only
  reg        iso_update_enable_bit;
  reg        function_inhibit;
  reg        resume_bit;
  reg        suspend_active_flag;
  reg        suspend_detect_enable;
  reg  [1:0] ep_index;
  reg  [3:1] in_pkt_ready;
  reg  [3:1] sent_stall;
  reg  [3:1] iso_mode;
  reg  [3:1] dir_in;
  reg  [3:1] split_mode;
  reg  [3:1] in_int_flag;
  reg        resume_int_flag;
  reg        iso_hold;
  reg  [1:0] pkt_ep;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [5:0] pkt_len;
  reg  [4:0] sync_a;
  reg  [4:0] sync_b;
  reg  [4:0] sync_prev;
  reg  [1:0] tok_ep_a;
  reg  [1:0] tok_ep_b;
  reg  [7:0] fetch_data;

  // link inputs come from outside the clock domain
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a    <= 5'h00;
      sync_b    <= 5'h00;
      sync_prev <= 5'h00;
      tok_ep_a  <= 2'h0;
      tok_ep_b  <= 2'h0;
    end else begin
      sync_a    <= {in_token_in, sof_in, bus_suspend_in, bus_resume_in, bus_reset_in};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      tok_ep_a  <= in_token_ep_in;
      tok_ep_b  <= tok_ep_a;
    end
  end
  reg vbus_a;
  reg vbus_b;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vbus_a <= 1'b0;
      vbus_b <= 1'b0;
    end else begin
      vbus_a <= vbus_in;
      vbus_b <= vbus_a;
    end
  end

  wire [4:0] rise      = sync_b & ~sync_prev;
  wire       bus_reset = sync_b[0];
  wire       resume_ev = rise[1];
  wire       susp_ev   = rise[2];
  wire       sof_ev    = rise[3];
  wire       token_ev  = rise[4];

  // soft reset acts asynchronously on the controller; driven from a flop so no glitch
  wire ctrl_rst_n = rst_n_in & ~soft_rst;
  wire enabled    = !function_inhibit;
  assign function_enabled_out = enabled;

  // sfr decode
  wire is_addr   = (sfr_addr_in == `SFR_INDIRECT_ADDR);
  wire is_data   = (sfr_addr_in == `SFR_INDIRECT_DATA);
  wire [5:0] tgt = indirect_address_port[5:0];
  wire wr_addr   = sfr_wr_in && is_addr;
  wire wr_data   = sfr_wr_in && is_data;
  wire rd_data   = sfr_rd_in && is_data;
  wire core_wr   = wr_data && !indirect_address_port[`IADDR_BUSY_BIT];
  wire fifo_tgt  = (tgt >= `CORE_FIFO_EP1) && (tgt <= `CORE_FIFO_EP3);
  wire fetch     = (wr_addr && sfr_wdata_in[`IADDR_BUSY_BIT])
                 || (rd_data && indirect_address_port[`IADDR_AUTO_READ_BIT]);
  wire ep_valid  = (ep_index != 2'd0);
  wire [1:0] sel = ep_index;
  wire [5:0] fetch_addr = wr_addr ? sfr_wdata_in[5:0] : tgt;

  // fifo
  wire       fifo_wr_ready;
  wire       fifo_rd_valid;
  wire       fifo_pop;
  wire       flush_req;
  wire       fifo_push = core_wr && fifo_tgt;
  assign sfr_ready_out = !(fifo_push && !fifo_wr_ready);

  in_data_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (ctrl_rst_n),
    .flush_in     (flush_req),
    .wr_data_in   (sfr_wdata_in),
    .wr_valid_in  (fifo_push),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (tx_data_out),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_pop)
  );

  // core register writes
  wire wr_power  = core_wr && (tgt == `CORE_POWER);
  wire wr_index  = core_wr && (tgt == `CORE_INDEX);
  wire wr_csrl   = core_wr && (tgt == `CORE_IN_CSRL) && ep_valid;
  wire wr_csrh   = core_wr && (tgt == `CORE_IN_CSRH) && ep_valid;
  assign flush_req = wr_csrl && sfr_wdata_in[`INCSRL_FLUSH_BIT];

  // power-on domain: sfr registers, soft reset, system reset
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      indirect_address_port   <= `IADDR_RESET;
      indirect_data_port      <= 8'h00;
      usb_reset_source_select <= 1'b0;
      vbus_polarity_select    <= 1'b0;
      soft_rst                <= 1'b0;
      sysrst_cnt              <= 5'd0;
      system_reset_out        <= 1'b0;
    end else begin
      soft_rst <= wr_power && sfr_wdata_in[`POWER_SOFT_RESET_BIT];
      if (sfr_wr_in && sfr_addr_in == `SFR_RESET_SOURCE) begin
        usb_reset_source_select <= sfr_wdata_in[`RESET_SOURCE_REGISTER_USB_SELECT_BIT];
      end
      if (sfr_wr_in && sfr_addr_in == `SFR_REGULATOR_CTRL) begin
        vbus_polarity_select <= sfr_wdata_in[`REGCTRL_VBUS_POL_BIT];
      end
      // busy reads one for the single fetch cycle
      if (wr_addr) begin
        indirect_address_port <= sfr_wdata_in;
      end else if (indirect_address_port[`IADDR_BUSY_BIT]) begin
        indirect_address_port[`IADDR_BUSY_BIT] <= 1'b0;
      end
      if (fetch) begin
        indirect_data_port <= fetch_data;
      end
      // select bit lives on power-on reset, so it still reads one afterwards
      if (sysrst_cnt != 5'd0) begin
        sysrst_cnt <= sysrst_cnt - 5'd1;
      end else if (usb_reset_source_select
          && ((bus_reset && enabled)
          || (vbus_b == vbus_polarity_select))) begin
        sysrst_cnt <= `SYS_RESET_CYCLES;
      end
      system_reset_out <= (sysrst_cnt != 5'd0);
    end
  end

  // core register read mux for the indirect fetch
  always @* begin
    fetch_data = 8'h00;
    case (fetch_addr)
      `CORE_POWER: begin
        fetch_data = {iso_update_enable_bit, 2'b00, function_inhibit, bus_reset,
                      resume_bit, suspend_active_flag, suspend_detect_enable};
      end
      `CORE_IN_INT: begin
        fetch_data = {4'h0, in_int_flag, 1'b0};
      end
      `CORE_COMMON_INT: begin
        fetch_data = {6'h00, resume_int_flag, 1'b0};
      end
      `CORE_INDEX: begin
        fetch_data = {6'h00, ep_index};
      end
      `CORE_IN_CSRL: begin
        if (ep_valid) begin
          fetch_data = {2'b00, sent_stall[sel], 3'b000,
                        fifo_rd_valid && (pkt_ep == sel), in_pkt_ready[sel]};
        end
      end
      `CORE_IN_CSRH: begin
        if (ep_valid) begin
          fetch_data = {1'b0, iso_mode[sel], dir_in[sel], 2'b00, split_mode[sel], 2'b00};
        end
      end
      default: begin
        fetch_data = 8'h00;
      end
    endcase
  end

  always @* begin
    sfr_rdata_out = 8'h00;
    case (sfr_addr_in)
      `SFR_INDIRECT_ADDR:  sfr_rdata_out = indirect_address_port;
      `SFR_INDIRECT_DATA:  sfr_rdata_out = indirect_data_port;
      `SFR_RESET_SOURCE:   sfr_rdata_out = {2'b00, usb_reset_source_select, 5'h00};
      `SFR_REGULATOR_CTRL: sfr_rdata_out = {1'b0, vbus_polarity_select, 6'h00};
      default:             sfr_rdata_out = 8'h00;
    endcase
  end

  // transmit engine
  wire tok_here  = token_ev && (tok_ep_b != 2'd0);
  wire [1:0] tep = tok_ep_b;
  wire in_capable = split_mode[tep] || dir_in[tep];
  wire has_pkt   = in_pkt_ready[tep] && (pkt_ep == tep);
  wire iso_zlp   = iso_mode[tep] && iso_update_enable_bit && iso_hold;
  wire start_tx  = (state == ST_IDLE) && enabled && tok_here && in_capable
                 && has_pkt && !iso_zlp && (pkt_len != 6'd0);
  assign tx_valid_out = (state == ST_SEND) && fifo_rd_valid;
  assign tx_last_out  = tx_valid_out && (pkt_len == 6'd1);
  assign fifo_pop     = tx_valid_out && tx_ready_in;
  wire tx_done        = fifo_pop && (pkt_len == 6'd1);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_tx) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_done || flush_req) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // clear-on-fetch of interrupt flags; a set in the same cycle wins
  wire clr_in_int  = fetch && (fetch_addr == `CORE_IN_INT);
  wire clr_cm_int  = fetch && (fetch_addr == `CORE_COMMON_INT);
  wire stall_ev    = (state == ST_IDLE) && enabled && tok_here && !in_capable;
  wire zlp_ev      = (state == ST_IDLE) && enabled && tok_here && in_capable
                   && ((has_pkt && iso_zlp) || (iso_mode[tep] && !has_pkt));
  wire nak_ev      = (state == ST_IDLE) && enabled && tok_here && in_capable
                   && !start_tx && !zlp_ev;

  always @(posedge clk_in or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      state           <= ST_IDLE;
      pkt_len         <= 6'd0;
      pkt_ep          <= 2'd0;
      iso_hold        <= 1'b0;
      tx_zero_len_out <= 1'b0;
      tx_stall_out    <= 1'b0;
      tx_nak_out      <= 1'b0;
      resume_int_flag <= 1'b0;
    end else begin
      state           <= next_state;
      tx_zero_len_out <= zlp_ev;
      tx_stall_out    <= stall_ev;
      tx_nak_out      <= nak_ev;
      if (flush_req || tx_done) begin
        pkt_len <= 6'd0;
      end else if (fifo_pop) begin
        pkt_len <= pkt_len - 6'd1;
      end else if (fifo_push && fifo_wr_ready) begin
        pkt_len <= pkt_len + 6'd1;
        pkt_ep  <= sel;
      end
      // held packets wait for the frame marker; one shared fifo, one pending packet
      if (wr_csrl && sfr_wdata_in[`INCSRL_PKT_READY_BIT] && iso_mode[sel]
          && iso_update_enable_bit) begin
        iso_hold <= 1'b1;
      end else if (sof_ev) begin
        iso_hold <= 1'b0;
      end
      if (resume_ev && resume_irq_enable_in) begin
        resume_int_flag <= 1'b1;
      end else if (clr_cm_int) begin
        resume_int_flag <= 1'b0;
      end
    end
  end

  // power register and endpoint state
  always @(posedge clk_in or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      iso_update_enable_bit <= POWER_RST[`POWER_ISO_UPDATE_BIT];
      function_inhibit      <= 1'b1;
      resume_bit            <= 1'b0;
      suspend_detect_enable <= 1'b0;
      suspend_active_flag   <= 1'b0;
      ep_index              <= 2'd0;
    end else begin
      if (wr_power) begin
        iso_update_enable_bit <= sfr_wdata_in[`POWER_ISO_UPDATE_BIT];
        resume_bit            <= sfr_wdata_in[`POWER_RESUME_BIT];
        suspend_detect_enable <= sfr_wdata_in[`POWER_SUSPEND_EN_BIT];
        if (!sfr_wdata_in[`POWER_INHIBIT_BIT]) begin
          function_inhibit <= 1'b0;
        end
      end
      if (wr_index) begin
        ep_index <= sfr_wdata_in[1:0];
      end
      if (resume_ev || resume_bit || bus_reset || system_reset_out) begin
        suspend_active_flag <= 1'b0;
      end else if (susp_ev && suspend_detect_enable && enabled) begin
        suspend_active_flag <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 1; g <= 3; g = g + 1) begin : g_ep
      wire sel_g = (sel == g);
      // held iso packet stays pending through the zero-length answer
      wire done_g = tx_done && (tep == g) && has_pkt;
      wire flush_g = flush_req && sel_g;
      always @(posedge clk_in or negedge ctrl_rst_n) begin
        if (!ctrl_rst_n) begin
          in_pkt_ready[g] <= 1'b0;
          sent_stall[g]   <= 1'b0;
          iso_mode[g]     <= 1'b0;
          dir_in[g]       <= 1'b0;
          split_mode[g]   <= 1'b0;
          in_int_flag[g]  <= 1'b0;
        end else begin
          if (done_g || flush_g) begin
            in_pkt_ready[g] <= 1'b0;
          end else if (wr_csrl && sel_g && sfr_wdata_in[`INCSRL_PKT_READY_BIT]) begin
            in_pkt_ready[g] <= 1'b1;
          end
          if (stall_ev && tep == g) begin
            sent_stall[g] <= 1'b1;
          end else if (wr_csrl && sel_g && !sfr_wdata_in[`INCSRL_SENT_STALL_BIT]) begin
            sent_stall[g] <= 1'b0;
          end
          if (wr_csrh && sel_g) begin
            iso_mode[g]   <= sfr_wdata_in[`INCSRH_ISO_BIT];
            dir_in[g]     <= sfr_wdata_in[`INCSRH_DIR_BIT];
            split_mode[g] <= sfr_wdata_in[`INCSRH_SPLIT_BIT];
          end
          // sent packet, flush with data, or stall each raise the flag
          if (done_g || (flush_g && fifo_rd_valid) || (stall_ev && tep == g)) begin
            in_int_flag[g] <= 1'b1;
          end else if (clr_in_int) begin
            in_int_flag[g] <= 1'b0;
          end
        end
      end
      assign ep_in_pipe_en_out[g]  = enabled && (split_mode[g] || dir_in[g]);
      assign ep_out_pipe_en_out[g] = enabled && (split_mode[g] || !dir_in[g]);
    end
  endgenerate

  // software must hold resume for 10-15 ms; no hardware timer enforces it
  assign remote_wakeup_out = resume_bit;
  assign osc_suspend_out   = suspend_active_flag;
  assign irq_out           = (|in_int_flag) || resume_int_flag;
endmodule // usb_function_power_endpoint_ctrl

// ==== hw/usb_power_ep_map.vh ====
/*
  register offsets, field positions, reset values and counts of the
  usb power / endpoint control block; assumes inclusion by bare name.
*/
`ifndef USB_POWER_EP_MAP_VH
`define USB_POWER_EP_MAP_VH

// special function register offsets on the firmware port
`define SFR_INDIRECT_ADDR        8'h96
`define SFR_INDIRECT_DATA        8'h97
`define SFR_RESET_SOURCE         8'hEF
`define SFR_REGULATOR_CTRL       8'hC9

// indirect address port fields
`define IADDR_BUSY_BIT           7
`define IADDR_AUTO_READ_BIT      6
`define IADDR_RESET              8'h00

// reset source / regulator fields
`define RESET_SOURCE_REGISTER_USB_SELECT_BIT    5
`define REGCTRL_VBUS_POL_BIT     6

// core register indirect addresses
`define CORE_POWER               6'h01
`define CORE_IN_INT              6'h02
`define CORE_COMMON_INT          6'h06
`define CORE_INDEX               6'h0E
`define CORE_IN_CSRL             6'h11
`define CORE_IN_CSRH             6'h12
`define CORE_FIFO_EP1            6'h21
`define CORE_FIFO_EP3            6'h23

// power register fields
`define POWER_RESET              8'h10
`define POWER_ISO_UPDATE_BIT     7
`define POWER_INHIBIT_BIT        4
`define POWER_SOFT_RESET_BIT     3
`define POWER_RESUME_BIT         2
`define POWER_SUSPEND_BIT        1
`define POWER_SUSPEND_EN_BIT     0

// in control-low / control-high fields
`define INCSRL_PKT_READY_BIT     0
`define INCSRL_FIFO_NE_BIT       1
`define INCSRL_FLUSH_BIT         3
`define INCSRL_SENT_STALL_BIT    5
`define INCSRH_ISO_BIT           6
`define INCSRH_DIR_BIT           5
`define INCSRH_SPLIT_BIT         2

// common interrupt fields
`define CINT_RESUME_BIT          1

// timing and fifo size
`define SYS_RESET_CYCLES         5'd16
`define FIFO_WIDTH               8
`define FIFO_DEPTH               32

`endif

// ==== hw/in_data_fifo.v ====
/*
  synchronous fifo with valid/ready on both sides and a flush input.
  assumes one clock; flush wins over a push in the same cycle.
*/
`timescale 1ns/1ps
module in_data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             flush_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire            empty = (wr_ptr == rd_ptr);
  wire            push  = wr_valid_in && !full && !flush_in;
  wire            pop   = rd_ready_in && !empty && !flush_in;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // in_data_fifo

// ==== tb/usb_ctrl_assertions.sv ====
/* port assertions for the usb power / endpoint block.
   assumes one clock and binding to the design top. */
`timescale 1ns/1ps
module usb_ctrl_assertions (
  input wire       clk_in,
  input wire       rst_n_in,
  input wire       bus_reset_in,
  input wire       tx_ready_in,
  input wire       tx_valid_out,
  input wire [7:0] tx_data_out,
  input wire       tx_last_out,
  input wire       tx_zero_len_out,
  input wire       tx_stall_out,
  input wire       tx_nak_out,
  input wire       system_reset_out,
  input wire       osc_suspend_out,
  input wire       function_enabled_out,
  input wire       irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_sixteen: assert property ($rose(system_reset_out) |->
    system_reset_out[*8] ##1 system_reset_out[*8] ##1 !system_reset_out)
    else $error("system reset not 16 cycles");
  a_off_after_reset: assert property ($rose(rst_n_in) |-> !function_enabled_out)
    else $error("enabled after reset");
  a_bus_reset_wakes: assert property (bus_reset_in[*6] |-> !osc_suspend_out)
    else $error("suspend kept in bus reset");
  a_last_with_valid: assert property (tx_last_out |-> tx_valid_out)
    else $error("last without valid");
  a_tx_hold_data: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("tx data dropped");
  a_one_answer: assert property ($onehot0({tx_zero_len_out, tx_stall_out,
    tx_nak_out, tx_valid_out})) else $error("two answers at once");
  a_stall_irq: assert property (tx_stall_out |-> ##[0:2] irq_out)
    else $error("stall without irq");
  a_sent_irq: assert property (tx_valid_out && tx_ready_in && tx_last_out
    |-> ##[1:2] irq_out) else $error("sent packet without irq");
  cover property ($rose(system_reset_out));
  cover property (tx_stall_out);
  cover property (tx_zero_len_out);
endmodule // usb_ctrl_assertions
bind usb_function_power_endpoint_ctrl usb_ctrl_assertions u_chk (.clk_in, .rst_n_in,
  .bus_reset_in, .tx_ready_in, .tx_valid_out, .tx_data_out, .tx_last_out,
  .tx_zero_len_out, .tx_stall_out, .tx_nak_out, .system_reset_out,
  .osc_suspend_out, .function_enabled_out, .irq_out);

// ==== tb/usb_host_model.sv ====
/* usb host stand-in: bus events, in tokens, a stalling sink.
   assumes the bench clock; events held 4 cycles for the 2-flop sync. */
`timescale 1ns/1ps
module usb_host_model (
  input  wire       clk_in,
  input  wire       tx_valid_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_last_in,
  input  wire       tx_zero_len_in,
  input  wire       tx_stall_in,
  input  wire       tx_nak_in,
  output reg        vbus_out,
  output reg        bus_reset_out,
  output wire       bus_resume_out,
  output wire       bus_suspend_out,
  output wire       sof_out,
  output reg        token_out,
  output reg  [1:0] token_ep_out,
  output reg        tx_ready_out
);
  reg     [2:0] ev;
  logic   [7:0] got[$];
  integer       resp;
  assign {sof_out, bus_suspend_out, bus_resume_out} = ev;
  initial begin
    {ev, bus_reset_out, token_out, token_ep_out, tx_ready_out} = 0;
    vbus_out = 1;
    resp = 0;
  end
  // half-rate sink, so the block must hold data while stalled
  always @(posedge clk_in) tx_ready_out <= #1 ~tx_ready_out;
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
    if (tx_valid_in && tx_ready_out && tx_last_in) resp <= 1;
    if (tx_zero_len_in) resp <= 2;
    if (tx_stall_in) resp <= 3;
    if (tx_nak_in) resp <= 4;
  end
  task pulse(input integer b);
    @(posedge clk_in);
    #1 ev[b] = 1;
    repeat (4) @(posedge clk_in);
    #1 ev[b] = 0;
    repeat (4) @(posedge clk_in);
  endtask
  task token(input [1:0] ep, output integer r);
    integer k;
    @(posedge clk_in);
    #1 token_ep_out = ep;
    resp = 0;
    got.delete();
    repeat (4) @(posedge clk_in);
    #1 token_out = 1;
    repeat (4) @(posedge clk_in);
    #1 token_out = 0;
    for (k = 0; resp == 0 && k < 200; k = k + 1) @(posedge clk_in);
    #1 r = resp;
  endtask
endmodule // usb_host_model

// ==== tb/testbench.sv ====
/* bench for the usb power / endpoint block over its sfr port.
   assumes the design, its map header and the host model. */
`timescale 1ns/1ps
module testbench;
  reg        clk_in, rst_n_in, wr, rd, irq_en;
  reg  [7:0] addr, wdata, d;
  wire [7:0] rdata, txd;
  wire       rdy, txv, txl, zl, st, nk, rst_o, rw, sus, en, irq;
  wire       vb, br, bres, bsus, sof, tok, txr;
  wire [1:0] tep;
  wire [3:1] pin, pout;
  integer    fail_count, num_checks, i, n, r;
  initial begin
    clk_in = 0;
    forever #2 clk_in = ~clk_in;
  end
  usb_function_power_endpoint_ctrl u_usb_function_power_endpoint_ctrl (.clk_in,
    .rst_n_in, .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_ready_out(rdy), .sfr_rdata_out(rdata),
    .resume_irq_enable_in(irq_en), .vbus_in(vb), .bus_reset_in(br),
    .bus_resume_in(bres), .bus_suspend_in(bsus), .sof_in(sof), .in_token_in(tok),
    .in_token_ep_in(tep), .tx_ready_in(txr), .tx_valid_out(txv), .tx_data_out(txd),
    .tx_last_out(txl), .tx_zero_len_out(zl), .tx_stall_out(st), .tx_nak_out(nk),
    .system_reset_out(rst_o), .remote_wakeup_out(rw), .osc_suspend_out(sus),
    .function_enabled_out(en), .ep_in_pipe_en_out(pin), .ep_out_pipe_en_out(pout),
    .irq_out(irq));
  usb_host_model u_usb_host_model (.clk_in, .tx_valid_in(txv), .tx_data_in(txd),
    .tx_last_in(txl), .tx_zero_len_in(zl), .tx_stall_in(st), .tx_nak_in(nk),
    .vbus_out(vb), .bus_reset_out(br), .bus_resume_out(bres), .bus_suspend_out(bsus),
    .sof_out(sof), .token_out(tok), .token_ep_out(tep), .tx_ready_out(txr));
  task chk(input [7:0] g, e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr_sfr(input [7:0] a, v);
    @(posedge clk_in);
    #1 addr = a;
    wdata = v;
    wr = 1;
    #1 for (n = 0; !rdy && n < 99; n = n + 1) @(posedge clk_in) #1;
    @(posedge clk_in);
    #1 wr = 0;
  endtask
  task rd_sfr(input [7:0] a);
    @(posedge clk_in);
    #1 addr = a;
    rd = 1;
    #1 d = rdata;
    @(posedge clk_in);
    #1 rd = 0;
  endtask
  task cw(input [5:0] a, input [7:0] v);
    wr_sfr(8'h96, {2'b00, a});
    wr_sfr(8'h97, v);
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task cr(input [5:0] a, input [7:0] m, e);
    wr_sfr(8'h96, {2'b10, a});
    rd_sfr(8'h97);
    chk(d & m, e);
  endtask
  task load(input [7:0] v);
    wr_sfr(8'h96, 8'h21);
    wr_sfr(8'h97, v);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    wrap_up;
  end
  initial begin
    {rst_n_in, wr, rd, addr, wdata, irq_en, fail_count, num_checks} = 0;
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1;
    chk(en, 0);
    rd_sfr(8'h55);
    chk(d, 8'h00); // unmapped place reads zero
    wr_sfr(8'h96, 8'h81);
    addr = 8'h96;
    #1 chk(rdata & 8'h80, 8'h80);
    @(posedge clk_in);
    #1 chk(rdata & 8'h80, 8'h00);
    rd_sfr(8'h97);
    chk(d & 8'hF5, 8'h10);
    cw(6'h01, 8'h08);
    chk(en, 0);
    cw(6'h01, 8'h00);
    chk(en, 1);
    cw(6'h01, 8'h08);
    chk(en, 0);
    cr(6'h01, 8'h10, 8'h10);
    cw(6'h01, 8'h01);
    $display("enable test done");
    for (i = 0; i < 2; i = i + 1) begin
      irq_en = i;
      u_usb_host_model.pulse(1);
      chk(sus, 1);
      u_usb_host_model.pulse(0);
      chk(sus, 0);
      chk(irq, i);
    end
    cr(6'h06, 8'h02, 8'h02);
    u_usb_host_model.pulse(1);
    cw(6'h01, 8'h05);
    chk({sus, rw}, 8'h01);
    // ended early here: the 10 ms wakeup span is not simulated
    cw(6'h01, 8'h01);
    chk(rw, 0);
    $display("suspend test done");
    cw(6'h0E, 8'h01);
    cw(6'h12, 8'h20);
    chk({pin[1], pout[1]}, 8'h02);
    for (i = 0; i < 32; i = i + 1) load(i);
    @(posedge clk_in);
    #1 wr = 1;
    #1 chk(rdy, 0); // full fifo refuses
    @(posedge clk_in);
    #1 wr = 0;
    cw(6'h11, 8'h01);
    u_usb_host_model.token(1, r);
    chk(r, 1);
    for (i = 0; i < 32; i = i + 1) chk(u_usb_host_model.got[i], i);
    chk(irq, 1);
    cr(6'h11, 8'h01, 8'h00);
    cr(6'h02, 8'h0E, 8'h02);
    u_usb_host_model.token(1, r);
    chk(r, 4); // nothing pending
    cw(6'h12, 8'h00);
    chk({pin[1], pout[1]}, 8'h01);
    u_usb_host_model.token(1, r);
    chk(r, 3);
    cr(6'h02, 8'h0E, 8'h02);
    cw(6'h12, 8'h04);
    chk({pin[1], pout[1]}, 8'h03);
    cw(6'h11, 8'h00);
    cw(6'h12, 8'h20);
    load(8'hA5);
    cw(6'h11, 8'h08);
    chk(irq, 1);
    cr(6'h11, 8'h02, 8'h00);
    cr(6'h02, 8'h0E, 8'h02);
    $display("in endpoint test done");
    cw(6'h01, 8'h80);
    cw(6'h12, 8'h60);
    load(8'h5A);
    cw(6'h11, 8'h01);
    u_usb_host_model.token(1, r);
    chk(r, 2);
    u_usb_host_model.pulse(2);
    u_usb_host_model.token(1, r);
    chk(r, 1);
    chk(u_usb_host_model.got[0], 8'h5A);
    $display("iso test done");
    u_usb_host_model.bus_reset_out = 1;
    repeat (10) @(posedge clk_in);
    chk(rst_o, 0);
    #1 wr_sfr(8'hEF, 8'h20);
    for (n = 0; !rst_o && n < 20; n = n + 1) @(posedge clk_in);
    chk(rst_o, 1);
    #1 u_usb_host_model.bus_reset_out = 0;
    repeat (40) @(posedge clk_in);
    rd_sfr(8'hEF);
    chk(d & 8'h20, 8'h20);
    wr_sfr(8'hC9, 8'h40);
    for (n = 0; !rst_o && n < 20; n = n + 1) @(posedge clk_in);
    chk(rst_o, 1);
    wr_sfr(8'hEF, 8'h00);
    $display("reset source test done");
    wrap_up;
  end
endmodule // testbench
